// [amer_alert_readout.sv]
// Summary of operation
// - mask one bits 1 and 2 suppress alert for processor and main supply limits
// - mask one bits 4, 5, 6 suppress remote one, local, remote two temperature
// - with all mask two bits set, override bit zero still lets status two alert
// - mask two bit 1 is read-only and masks the thermal pin overtemperature event
// - mask two bits 2, 3, 4 mask fan one, two, three faults
// - mask two bit 5 masks fan four, or thermal timer when tach four is thermal
// - mask two bits 6, 7 mask remote one and two diode faults
// - voltage low bits register holds processor bits 3:2, main supply bits 5:4
// - temperature low bits: remote one 3:2, local 5:4, remote two 7:6
// - reading a low-bits register freezes it and its upper registers until read
// - alert pin acts as alert only while the alert enable bit is one
// - thermal timer over its limit sets status two bit 5 only while tach four is thermal
`timescale 1ns/100ps
`default_nettype none
module amer_alert_readout
   import amer_pkg::*;
#(
   parameter int RW = 10
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   input wire logic [7:0] status_one_in,
   input wire logic [7:0] status_two_in,
   input wire logic overtemp_pin_mask_in,
   input wire logic fourth_tach_input_is_thermal_in,
   input wire logic thermal_timer_over_in,
   input wire logic alert_pin_enable_in,
   input wire logic [CHAN_N*RW-1:0] result_in,
   input wire logic [CHAN_N-1:0] result_valid_in,
   output logic alert_active_out,
   output logic alert_pin_out,
   output logic alert_pin_oe_n_out,
   output logic [CHAN_N-1:0] frozen_out
);
   logic [7:0] mask_one_q;
   logic [7:0] mask_one_d;
   logic [7:0] mask_two_q;
   logic [7:0] mask_two_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [CHAN_N*RW-1:0] value_w;
   logic [CHAN_N-1:0] pending_w;
   logic [CHAN_N-1:0] freeze_set_w;
   logic [CHAN_N-1:0] upper_read_w;
   logic [7:0] status_two_eff_w;
   logic [7:0] st_one_unmasked_w;
   logic [7:0] st_two_unmasked_w;
   logic all_two_masked_w;
   logic override_w;
   logic alert_w;
   logic [7:0] volt_low_w;
   logic [7:0] temp_low_w;
   logic wr_one_w;
   logic wr_two_w;
   logic rd_volt_w;
   logic rd_temp_w;

   // address decode strobes
   assign wr_one_w = reg_wr_in && (reg_addr_in == MASK_ONE_ADDR);
   assign wr_two_w = reg_wr_in && (reg_addr_in == MASK_TWO_ADDR);
   assign rd_volt_w = reg_rd_in && (reg_addr_in == VOLT_LOW_ADDR);
   assign rd_temp_w = reg_rd_in && (reg_addr_in == TEMP_LOW_ADDR);

   // mask register next values; bit 1 of register two tracks its source
   assign mask_one_d = wr_one_w ? (reg_wdata_in & MASK_ONE_WMASK) : mask_one_q;
   assign mask_two_d = {wr_two_w ? reg_wdata_in[7:2] : mask_two_q[7:2],
                        overtemp_pin_mask_in, 1'b0};

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         mask_one_q <= MASK_ONE_RST;
         mask_two_q <= MASK_TWO_RST;
      end else if (ce_in) begin
         mask_one_q <= mask_one_d;
         mask_two_q <= mask_two_d;
      end
   end

   // bit 5 source follows the fourth tach pin role
   // timer overrun lands on status two bit 5
   assign status_two_eff_w = {status_two_in[7:6],
                              fourth_tach_input_is_thermal_in ? thermal_timer_over_in
                                                              : status_two_in[5],
                              status_two_in[4:0]};

   // per-source masking of register one sources
   assign st_one_unmasked_w = status_one_in & ~mask_one_q & MASK_ONE_WMASK
                              & ~(8'h01 << OVERRIDE_BIT);
   // per-source masking of register two sources
   assign st_two_unmasked_w = status_two_eff_w & ~mask_two_q & MASK_TWO_SRC;
   // override lets status two through when every mask two bit is set
   assign all_two_masked_w = ((mask_two_q & MASK_TWO_SRC) == MASK_TWO_SRC);
   assign override_w = !mask_one_q[OVERRIDE_BIT] && all_two_masked_w
                       && |(status_two_eff_w & MASK_TWO_SRC);
   // level alert from any unmasked event
   assign alert_w = |st_one_unmasked_w || |st_two_unmasked_w || override_w;
   assign alert_active_out = alert_w;
   // open-drain alert pin only when enabled; level always low
   assign alert_pin_out = 1'b0;
   assign alert_pin_oe_n_out = !(alert_w && alert_pin_enable_in);

   // freeze arming per group, upper reads per channel
   // group freeze on low-bits read
   assign freeze_set_w = {rd_temp_w, rd_temp_w, rd_temp_w, rd_volt_w, rd_volt_w};
   assign upper_read_w[CH_PROC] = reg_rd_in && (reg_addr_in == PROC_HIGH_ADDR);
   assign upper_read_w[CH_MAIN] = reg_rd_in && (reg_addr_in == MAIN_HIGH_ADDR);
   assign upper_read_w[CH_REM1] = reg_rd_in && (reg_addr_in == REM1_HIGH_ADDR);
   assign upper_read_w[CH_LOCAL] = reg_rd_in && (reg_addr_in == LOCAL_HIGH_ADDR);
   assign upper_read_w[CH_REM2] = reg_rd_in && (reg_addr_in == REM2_HIGH_ADDR);

   // one holder per measured channel
   // frozen channels drop new results
   genvar gi;
   generate
      for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
         amer_reading_hold #(.WIDTH(RW)) u_hold (
            .core_clk_in(core_clk_in),
            .srst_in(srst_in),
            .ce_in(ce_in),
            .result_in(result_in[gi*RW +: RW]),
            .result_valid_in(result_valid_in[gi]),
            .freeze_set_in(freeze_set_w[gi]),
            .upper_read_in(upper_read_w[gi]),
            .value_out(value_w[gi*RW +: RW]),
            .pending_out(pending_w[gi])
         );
      end
   endgenerate
   assign frozen_out = pending_w;

   assign volt_low_w = {2'b00, value_w[CH_MAIN*RW +: 2], value_w[CH_PROC*RW +: 2], 2'b00};
   assign temp_low_w = {value_w[CH_REM2*RW +: 2], value_w[CH_LOCAL*RW +: 2],
                        value_w[CH_REM1*RW +: 2], 2'b00};

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = READ_ZERO;
      if (reg_addr_in == MASK_ONE_ADDR) begin
         rdata_d = mask_one_q;
      end else if (reg_addr_in == MASK_TWO_ADDR) begin
         rdata_d = mask_two_q;
      end else if (reg_addr_in == VOLT_LOW_ADDR) begin
         rdata_d = volt_low_w;
      end else if (reg_addr_in == TEMP_LOW_ADDR) begin
         rdata_d = temp_low_w;
      end else if (reg_addr_in == PROC_HIGH_ADDR) begin
         rdata_d = value_w[CH_PROC*RW + 2 +: 8];
      end else if (reg_addr_in == MAIN_HIGH_ADDR) begin
         rdata_d = value_w[CH_MAIN*RW + 2 +: 8];
      end else if (reg_addr_in == REM1_HIGH_ADDR) begin
         rdata_d = value_w[CH_REM1*RW + 2 +: 8];
      end else if (reg_addr_in == LOCAL_HIGH_ADDR) begin
         rdata_d = value_w[CH_LOCAL*RW + 2 +: 8];
      end else if (reg_addr_in == REM2_HIGH_ADDR) begin
         rdata_d = value_w[CH_REM2*RW + 2 +: 8];
      end
   end

   // read data captured on the read strobe and held until the next read
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         rdata_q <= READ_ZERO;
      end else if (ce_in && reg_rd_in) begin
         rdata_q <= rdata_d;
      end
   end
   assign reg_rdata_out = rdata_q;

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (srst_in);

   proc_supply_mask_a: assert property (
      mask_one_q[PROC_MASK_BIT] && (status_one_in == 8'h02) && (status_two_eff_w == 8'h00)
      |-> !alert_w)
      else $error("processor supply alert not masked");
   temp_mask_a: assert property (
      !mask_one_q[LOCAL_MASK_BIT] && status_one_in[LOCAL_MASK_BIT] |-> alert_w)
      else $error("unmasked local temperature event gave no alert");
   override_bit_a: assert property (
      all_two_masked_w && (status_one_in == 8'h00) && |(status_two_eff_w & MASK_TWO_SRC)
      |-> (alert_w == !mask_one_q[OVERRIDE_BIT]))
      else $error("status two override misbehaves");
   ovt_readonly_a: assert property (
      ce_in && wr_two_w |=> (mask_two_q[OVT_MASK_BIT] == $past(overtemp_pin_mask_in)))
      else $error("overtemp mask bit written by software");
   fan_mask_a: assert property (
      ce_in && wr_two_w && reg_wdata_in[SECOND_FAN_FAULT_MASK_MASK_BIT] |=> mask_two_q[SECOND_FAN_FAULT_MASK_MASK_BIT])
      else $error("fan two mask not stored");
   timer_route_a: assert property (
      fourth_tach_input_is_thermal_in && thermal_timer_over_in
      && !mask_two_q[FAN4_MASK_BIT] |-> alert_w)
      else $error("thermal timer alert lost");
   pin_enable_a: assert property (
      !alert_pin_enable_in |-> alert_pin_oe_n_out)
      else $error("alert pin driven while disabled");
   freeze_hold_a: assert property (
      ce_in && rd_volt_w ##1 !upper_read_w[CH_PROC] && !srst_in
      |-> pending_w[CH_PROC])
      else $error("voltage group not frozen after low read");
   frozen_stable_a: assert property (
      pending_w[CH_REM1] && !upper_read_w[CH_REM1] && !freeze_set_w[CH_REM1]
      |=> $stable(value_w[CH_REM1*RW +: RW]))
      else $error("frozen reading changed");
   low_pack_a: assert property (
      ce_in && rd_temp_w |=> reg_rdata_out[7:6] == $past(value_w[CH_REM2*RW +: 2]))
      else $error("remote two low bits misplaced");

   cover_override_c: cover property (override_w ##1 mask_one_q[OVERRIDE_BIT]);
   cover_freeze_c: cover property (rd_temp_w ##[1:20] upper_read_w[CH_LOCAL]);
   cover_alert_c: cover property (!alert_pin_oe_n_out ##[1:50] alert_pin_oe_n_out);
endmodule
`default_nettype wire

// [amer_pkg.sv]
package amer_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] MASK_ONE_ADDR = 8'h74;
   localparam logic [7:0] MASK_TWO_ADDR = 8'h75;
   localparam logic [7:0] VOLT_LOW_ADDR = 8'h76;
   localparam logic [7:0] TEMP_LOW_ADDR = 8'h77;
   // upper-bit reading registers served by this block
   localparam logic [7:0] PROC_HIGH_ADDR = 8'h21;
   localparam logic [7:0] MAIN_HIGH_ADDR = 8'h22;
   localparam logic [7:0] REM1_HIGH_ADDR = 8'h25;
   localparam logic [7:0] LOCAL_HIGH_ADDR = 8'h26;
   localparam logic [7:0] REM2_HIGH_ADDR = 8'h27;
   // reset values
   localparam logic [7:0] MASK_ONE_RST = 8'h00;
   localparam logic [7:0] MASK_TWO_RST = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // mask register one fields
   localparam int PROC_MASK_BIT = 1;
   localparam int MAIN_MASK_BIT = 2;
   localparam int REM1_MASK_BIT = 4;
   localparam int LOCAL_MASK_BIT = 5;
   localparam int REM2_MASK_BIT = 6;
   localparam int OVERRIDE_BIT = 7;
   // writable bits of register one; its alert sources are these less the override bit 7
   localparam logic [7:0] MASK_ONE_WMASK = 8'hF6;
   // mask register two fields
   localparam int OVT_MASK_BIT = 1;
   localparam int FIRST_FAN_FAULT_MASK_MASK_BIT = 2;
   localparam int SECOND_FAN_FAULT_MASK_MASK_BIT = 3;
   localparam int THIRD_FAN_FAULT_MASK_MASK_BIT = 4;
   localparam int FAN4_MASK_BIT = 5;
   localparam int DIODE1_MASK_BIT = 6;
   localparam int DIODE2_MASK_BIT = 7;
   // software writes only bits 7:2 of register two
   localparam logic [7:0] MASK_TWO_WMASK = 8'hFC;
   // status two sources that the mask register two governs (bits 7:1)
   localparam logic [7:0] MASK_TWO_SRC = 8'hFE;
   // field positions of the low bits
   localparam int PROC_LOW_POS = 2;
   localparam int MAIN_LOW_POS = 4;
   localparam int REM1_LOW_POS = 2;
   localparam int LOCAL_LOW_POS = 4;
   localparam int REM2_LOW_POS = 6;
   // reading width and channel count
   localparam int READ_W = 10;
   localparam int CHAN_N = 5;
   localparam int CH_PROC = 0;
   localparam int CH_MAIN = 1;
   localparam int CH_REM1 = 2;
   localparam int CH_LOCAL = 3;
   localparam int CH_REM2 = 4;
endpackage

// [amer_reading_hold.sv]
`timescale 1ns/100ps
`default_nettype none
module amer_reading_hold #(
   parameter int WIDTH = 10
) (
   input wire logic core_clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   input wire logic [WIDTH-1:0] result_in,
   input wire logic result_valid_in,
   input wire logic freeze_set_in,
   input wire logic upper_read_in,
   output logic [WIDTH-1:0] value_out,
   output logic pending_out
);
   logic [WIDTH-1:0] value_q;
   logic pending_q;
   logic take_w;

   // a result landing on the freezing edge is dropped too, so both halves match
   assign take_w = result_valid_in && !pending_q && !freeze_set_in;

   // reading value, discarded while the channel is frozen
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         value_q <= '0;
      end else if (ce_in && take_w) begin
         value_q <= result_in;
      end
   end

   // freeze flag: arming wins over the upper read in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         pending_q <= 1'b0;
      end else if (ce_in) begin
         if (freeze_set_in) begin
            pending_q <= 1'b1;
         end else if (upper_read_in) begin
            pending_q <= 1'b0;
         end
      end
   end

   assign value_out = value_q;
   assign pending_out = pending_q;
endmodule
`default_nettype wire

// [amer_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// register-port host; every strobe changes just after a falling edge
module amer_host_model (
   input wire logic core_clk_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out
);
   // idle bus at time zero
   initial begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   // one write, held across exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge core_clk_in);
      reg_wr_out = 1'b0;
      reg_wdata_out = ~d; // released data never shows the last value
   endtask
   // one read; data is registered, so it is taken half a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge core_clk_in);
      reg_rd_out = 1'b0;
      reg_addr_out = ~a;
      d = reg_rdata_in;
   endtask
   // low bits first
   // the upper half follows so both halves come from one conversion
   task automatic rd_pair(input logic [7:0] lo_a, input logic [7:0] hi_a,
                          output logic [7:0] lo, output logic [7:0] hi);
      rd(lo_a, lo);
      rd(hi_a, hi);
   endtask
endmodule
`default_nettype wire

// [alert_mask_and_extended_readout_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module alert_mask_and_extended_readout_tb;
   import amer_pkg::*;
   logic core_clk_in, srst_in, reg_wr, reg_rd, overtemp_pin_mask, sel, tmr, en, alert, pin, oe_n;
   logic ce;
   logic [7:0] addr, wdata, rdata, s1, s2, v, w;
   logic [49:0] result;
   logic [4:0] valid, frozen;
   int err_total = 0;
   int n_checks = 0;
   // masks one, two, status one, two, expected alert
   logic [32:0] rows [16] = '{
      {8'h00, 8'h00, 8'h02, 8'h00, 1'b1},
      {8'h02, 8'h00, 8'h02, 8'h00, 1'b0},
      {8'h04, 8'h00, 8'h04, 8'h00, 1'b0},
      {8'h04, 8'h00, 8'h06, 8'h00, 1'b1},
      {8'h70, 8'h00, 8'h70, 8'h00, 1'b0},
      {8'h60, 8'h00, 8'h70, 8'h00, 1'b1},
      {8'h50, 8'h00, 8'h60, 8'h00, 1'b1},
      {8'h00, 8'hFE, 8'h00, 8'hFE, 1'b1},
      {8'h80, 8'hFE, 8'h00, 8'hFE, 1'b0},
      {8'h80, 8'hFC, 8'h00, 8'h02, 1'b1},
      {8'h80, 8'hFE, 8'h00, 8'h02, 1'b0},
      {8'h80, 8'h1C, 8'h00, 8'h1C, 1'b0},
      {8'h80, 8'h14, 8'h00, 8'h1C, 1'b1},
      {8'h80, 8'h20, 8'h00, 8'h20, 1'b0},
      {8'h80, 8'h40, 8'h00, 8'hC0, 1'b1},
      {8'h80, 8'hC0, 8'h00, 8'hC0, 1'b0}
   };
   amer_alert_readout #(.RW(10)) uut (.core_clk_in(core_clk_in), .srst_in(srst_in),
      .ce_in(ce), .reg_addr_in(addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .status_one_in(s1),
      .status_two_in(s2), .overtemp_pin_mask_in(overtemp_pin_mask),
      .fourth_tach_input_is_thermal_in(sel), .thermal_timer_over_in(tmr),
      .alert_pin_enable_in(en), .result_in(result), .result_valid_in(valid),
      .alert_active_out(alert), .alert_pin_out(pin), .alert_pin_oe_n_out(oe_n),
      .frozen_out(frozen));
   amer_host_model host (.core_clk_in(core_clk_in), .reg_rdata_in(rdata),
      .reg_addr_out(addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
      .reg_wdata_out(wdata));
   // 25 MHz clock
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk8(d, e);
   endtask
   task automatic summarize;
      if (err_total == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // whole run is well under a thousand cycles
   initial begin
      repeat (4000) @(posedge core_clk_in);
      err_total++;
      summarize();
   end
   // main sequence; inputs move on the falling edge
   initial begin
      logic [7:0] m1, m2, s1v, s2v;
      logic ex;
      srst_in = 1'b1;
      {overtemp_pin_mask, sel, tmr, en, s1, s2, result, valid} = '0;
      en = 1'b1;
      ce = 1'b1;
      repeat (16) @(posedge core_clk_in);
      @(negedge core_clk_in);
      srst_in = 1'b0;
      rdc(MASK_ONE_ADDR, MASK_ONE_RST);
      rdc(MASK_TWO_ADDR, MASK_TWO_RST);
      chk8({3'b000, frozen}, 8'h00);
      foreach (rows[i]) begin
         {m1, m2, s1v, s2v, ex} = rows[i];
         overtemp_pin_mask = m2[1];
         host.wr(MASK_ONE_ADDR, m1);
         host.wr(MASK_TWO_ADDR, m2);
         s1 = s1v;
         s2 = s2v;
         @(negedge core_clk_in);
         chk1(alert, ex);
         chk1(oe_n, ~ex);
         chk1(pin, 1'b0);
         rdc(MASK_ONE_ADDR, m1 & MASK_ONE_WMASK);
         rdc(MASK_TWO_ADDR, m2);
      end
      // reserved and read-only bits refuse writes, unmapped reads zero
      overtemp_pin_mask = 1'b0;
      host.wr(MASK_ONE_ADDR, 8'hFF);
      host.wr(MASK_TWO_ADDR, 8'hFF);
      rdc(MASK_ONE_ADDR, 8'hF6);
      rdc(MASK_TWO_ADDR, 8'hFC);
      rdc(8'h50, 8'h00);
      // thermal timer replaces the fourth fan source
      host.wr(MASK_TWO_ADDR, 8'h00);
      sel = 1'b1;
      s2 = 8'h20;
      @(negedge core_clk_in);
      chk1(alert, 1'b0);
      tmr = 1'b1;
      @(negedge core_clk_in);
      chk1(alert, 1'b1);
      host.wr(MASK_TWO_ADDR, 8'h20);
      chk1(alert, 1'b0);
      en = 1'b0;
      host.wr(MASK_TWO_ADDR, 8'h00);
      chk1(alert, 1'b1);
      chk1(oe_n, 1'b1);
      {sel, tmr, s2} = '0;
      // freeze: results arriving while frozen must be dropped
      result = {10'h1B3, 10'h0FE, 10'h301, 10'h15E, 10'h2A7};
      valid = 5'h1F;
      @(negedge core_clk_in);
      valid = 5'h00;
      rdc(VOLT_LOW_ADDR, 8'h2C);
      chk8({3'b000, frozen}, 8'h03);
      result = {5{10'h3FF}};
      valid = 5'h1F;
      @(negedge core_clk_in);
      valid = 5'h00;
      rdc(PROC_HIGH_ADDR, 8'hA9);
      rdc(MAIN_HIGH_ADDR, 8'h57);
      chk8({3'b000, frozen}, 8'h00);
      rdc(TEMP_LOW_ADDR, 8'hFC);
      chk8({3'b000, frozen}, 8'h1C);
      rdc(REM1_HIGH_ADDR, 8'hFF);
      rdc(LOCAL_HIGH_ADDR, 8'hFF);
      rdc(REM2_HIGH_ADDR, 8'hFF);
      host.rd_pair(VOLT_LOW_ADDR, PROC_HIGH_ADDR, v, w);
      chk8(v, 8'h2C);
      chk8(w, 8'hA9);
      rdc(MAIN_HIGH_ADDR, 8'h57);
      chk8({3'b000, frozen}, 8'h00);
      // clock enable low must keep a write from landing
      ce = 1'b0;
      host.wr(MASK_ONE_ADDR, 8'h00);
      ce = 1'b1;
      rdc(MASK_ONE_ADDR, 8'hF6);
      // reset in mid-run clears masks, readings and a standing freeze
      rdc(VOLT_LOW_ADDR, 8'h2C);
      chk8({3'b000, frozen}, 8'h03);
      srst_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      srst_in = 1'b0;
      chk8({3'b000, frozen}, 8'h00);
      rdc(MASK_ONE_ADDR, MASK_ONE_RST);
      rdc(PROC_HIGH_ADDR, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
